// ---- core/pms_consts.svh ----
// Constants for the programmable Mealy sequencer: offsets, fields, reset values
//
// What this block does
// - Power-up sets all state and output bits
// - Virgin device selects preset, not output enable
// - Virgin transition terms always evaluate zero
// - Virgin J and K inputs held at zero
// - Load modes float pins; outside drives levels
// - Complement array ORs terms, inverts, feeds back
// - Complement output high only when terms idle
// - Observe mode shows state; logic mode shows outputs
// - Registers update on rising edge, pins follow
// - Preset forces outputs high without clock edge
// - Output-enable option high floats output pins
// - Observe shows six state bits, outputs hold
// - State-load edge copies low pins into state
// - Preset sets all bits, blocks clocking until low and a clock falling edge
// - Flip-flops act as rising-edge J-K elements
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// ----------------------------------------------------------------
// Array dimensions
// ----------------------------------------------------------------
`define PMS_NUM_TERMS     48
`define PMS_NUM_INPUTS    16
`define PMS_STATE_W       6
`define PMS_OUT_W         8
`define PMS_VAR_W         23
`define PMS_REG_W         14
`define PMS_WORDS_PER_TERM 4

// ----------------------------------------------------------------
// Word addresses on the register port
// ----------------------------------------------------------------
`define PMS_ADDR_W        8
`define PMS_ADDR_CONFIG   8'hc0
`define PMS_ADDR_STATUS   8'hc1

// ----------------------------------------------------------------
// Fields inside each term's four program words and the config word
// ----------------------------------------------------------------
`define PMS_SEL_TRUE      2'h0
`define PMS_SEL_COMP      2'h1
`define PMS_SEL_JCON      2'h2
`define PMS_SEL_KCON      2'h3
`define PMS_VAR_C_BIT     22
`define PMS_KCON_CARR_BIT 14
`define PMS_CFG_OE_BIT    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMS_PROG_RESET    32'hffffffff
`define PMS_CFG_RESET     1'h0
`define PMS_STATE_RESET   6'h3f
`define PMS_OUT_RESET     8'hff

`endif

// ---- core/pms_pkg.sv ----
// Types shared by the programmable Mealy sequencer files
package pms_pkg;

    // ----------------------------------------------------------------
    // Pin samples that cross into the clk_i domain
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        seq_clk;          // Sequencer clock pin
        logic        preset_or_enable; // Shared preset or enable pin
        logic        state_observe;    // Diagnostic observe level
        logic        state_load;       // Diagnostic state load level
        logic        output_load;      // Diagnostic output load level
        logic [15:0] logic_in;         // AND array inputs
        logic [7:0]  pins_in;          // Levels seen on output pins
    } pms_pin_s;

    // ----------------------------------------------------------------
    // Register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;  // Word address
        logic [31:0] wdata; // Write data
        logic        we;    // Write strobe
        logic        re;    // Read strobe
    } pms_bus_s;

    // Word of the program store
    typedef logic [31:0] pms_word_t;

endpackage : pms_pkg

// ---- core/pms_prog_mem.sv ----
// Program store for the sequencer arrays, with registered read data
`timescale 1ns/1ns
`include "pms_consts.svh"

module pms_prog_mem #(
    parameter int DEPTH = 192
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire pms_pkg::pms_bus_s     bus_i,
    input  wire pms_pkg::pms_word_t    aux_data_i,
    output pms_pkg::pms_word_t         rdata_o,
    output pms_pkg::pms_word_t         words_o [DEPTH]
);
    import pms_pkg::*;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    pms_word_t mem_reg  [DEPTH];  // Link pattern words
    pms_word_t mem_next [DEPTH];  // Next link pattern words
    pms_word_t rdata_reg;         // Read data register
    pms_word_t rdata_next;        // Next read data
    logic      in_range;          // Address hits the store

    assign in_range = ({24'h0, bus_i.addr} < 32'(DEPTH));

    // Write and read selection
    always_comb
    begin
        mem_next   = mem_reg;
        rdata_next = rdata_reg;
        if (bus_i.we && in_range)
        begin
            mem_next[bus_i.addr] = bus_i.wdata;
        end
        if (bus_i.re)
        begin
            // Outside the store the top supplies its own answer
            rdata_next = in_range ? mem_reg[bus_i.addr] : aux_data_i;
        end
    end

    // Virgin links all intact: every term inhibited, no J or K drive
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= `PMS_PROG_RESET;
            end
            rdata_reg <= 32'h0;
        end
        else
        begin
            mem_reg   <= mem_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign words_o = mem_reg;

endmodule : pms_prog_mem

// ---- core/pms_sequencer.sv ----
// Programmable Mealy sequencer: AND, OR and complement arrays with J-K registers
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ns
`include "pms_consts.svh"

module pms_sequencer #(
    parameter int NUM_TERMS = `PMS_NUM_TERMS
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // Register port
    input  wire logic [7:0]           addr_i,
    input  wire logic [31:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic [31:0]               rdata_o,
    // Device pins, asynchronous to clk_i
    input  wire logic                 seq_clk_i,
    input  wire logic                 preset_or_enable_pin_i,
    input  wire logic                 state_observe_input_i,
    input  wire logic                 state_load_input_i,
    input  wire logic                 output_load_input_i,
    input  wire logic [15:0]          logic_in_i,
    input  wire logic [7:0]           output_pins_i,
    output logic [7:0]                output_pins_o,
    output logic [7:0]                output_pins_oe_o
);
    import pms_pkg::*;

    localparam int DEPTH = NUM_TERMS * `PMS_WORDS_PER_TERM;

    // ----------------------------------------------------------------
    // J-K and array helper functions
    // ----------------------------------------------------------------

    // Vector J-K update: hold, clear, set or toggle per bit
    function automatic logic [13:0] jk_update(
        input logic [13:0] q,
        input logic [13:0] j,
        input logic [13:0] k
    );
        jk_update = (j & ~q) | (~k & q);
    endfunction : jk_update

    // One AND gate: intact true link needs 1, intact complement link 0
    function automatic logic term_eval(
        input logic [22:0] true_link,
        input logic [22:0] comp_link,
        input logic [22:0] vars
    );
        // Both links intact on any variable inhibits the gate
        term_eval = &((~true_link | vars) & (~comp_link | ~vars));
    endfunction : term_eval

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pms_pin_s pin_raw;   // Pins as they arrive
    pms_pin_s pin_s1;    // First stage, read only by second stage
    pms_pin_s pin_s2;    // Safe copy for logic

    assign pin_raw = '{seq_clk:          seq_clk_i,
                       preset_or_enable: preset_or_enable_pin_i,
                       state_observe:    state_observe_input_i,
                       state_load:       state_load_input_i,
                       output_load:      output_load_input_i,
                       logic_in:         logic_in_i,
                       pins_in:          output_pins_i};

    // Two-stage synchroniser on every pin
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    // ----------------------------------------------------------------
    // Program store
    // ----------------------------------------------------------------
    pms_bus_s  bus;              // Packed bus request
    pms_word_t aux_data;         // Answer for addresses above the store
    pms_word_t words [DEPTH];    // All link words

    assign bus = '{addr: addr_i, wdata: wdata_i, we: wr_i, re: rd_i};

    pms_prog_mem #(
        .DEPTH (DEPTH)
    ) u_prog_mem (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .bus_i      (bus),
        .aux_data_i (aux_data),
        .rdata_o    (rdata_o),
        .words_o    (words)
    );

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    logic [5:0] state_reg;     // Buried state register
    logic [5:0] state_next;
    logic [7:0] out_reg;       // Output register
    logic [7:0] out_next;
    logic       oe_opt_reg;    // Shared pin acts as output enable
    logic       oe_opt_next;
    logic       clk_prev_reg;  // Last synchronised clock level
    logic       lockout_reg;   // Clocking blocked after preset
    logic       lockout_next;
    logic [7:0] pins_reg;      // Driven pin levels
    logic [7:0] pins_next;
    logic [7:0] pins_oe_reg;   // Pin drive enables
    logic [7:0] pins_oe_next;

    // ----------------------------------------------------------------
    // Configuration and status decode
    // ----------------------------------------------------------------

    // Config write and read answer outside the store
    always_comb
    begin
        oe_opt_next = oe_opt_reg;
        aux_data    = 32'h0;
        if (addr_i == `PMS_ADDR_CONFIG)
        begin
            // Option select for the shared pin
            if (wr_i)
            begin
                oe_opt_next = wdata_i[`PMS_CFG_OE_BIT];
            end
            aux_data = {31'h0, oe_opt_reg};
        end
        else if (addr_i == `PMS_ADDR_STATUS)
        begin
            // Live register contents and lockout flag
            aux_data = {15'h0, lockout_reg, out_reg, 2'h0, state_reg};
        end
        else
        begin
            // Unmapped words read as zero
            aux_data = 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // AND array, complement array and OR array
    // ----------------------------------------------------------------
    logic [NUM_TERMS-1:0] pass1;       // Terms without complement factor
    logic [NUM_TERMS-1:0] terms;       // Final transition terms
    logic [NUM_TERMS-1:0] carr_conn;   // Terms wired into complement array
    logic                 carr_out;    // Complement array output
    logic [13:0]          j_vec;       // J inputs, state then outputs
    logic [13:0]          k_vec;       // K inputs, state then outputs
    logic [22:0]          vars_nc;     // Variables with complement forced

    assign vars_nc = {1'b0, state_reg, pin_s2.logic_in};

    // Two passes so a term can never feed itself through the NOR
    always_comb
    begin
        pass1     = '0;
        terms     = '0;
        carr_conn = '0;
        j_vec     = 14'h0;
        k_vec     = 14'h0;
        for (int t = 0; t < NUM_TERMS; t++)
        begin
            // First pass ignores the complement variable entirely
            pass1[t] = term_eval(
                {1'b0, words[t*4][21:0]},
                {1'b0, words[t*4+1][21:0]},
                vars_nc);
            carr_conn[t] = words[t*4+3][`PMS_KCON_CARR_BIT];
        end
        // Low when any connected term is active, high otherwise
        carr_out = ~|(pass1 & carr_conn);
        for (int t = 0; t < NUM_TERMS; t++)
        begin
            // Second pass applies the inverted OR as an extra input
            terms[t] = pass1[t] & term_eval(
                {words[t*4][`PMS_VAR_C_BIT], 22'h0},
                {words[t*4+1][`PMS_VAR_C_BIT], 22'h0},
                {carr_out, 22'h0});
            // OR array: an idle term contributes nothing
            j_vec = j_vec | ({14{terms[t]}} & words[t*4+2][13:0]);
            k_vec = k_vec | ({14{terms[t]}} & words[t*4+3][13:0]);
        end
    end

    // ----------------------------------------------------------------
    // Register update, preset and diagnostic modes
    // ----------------------------------------------------------------
    logic        clk_rise;      // Sequencer clock rising edge
    logic        clk_fall;      // Sequencer clock falling edge
    logic        preset_act;    // Preset option asserted
    logic        drive_ok;      // Output enable allows drive
    logic        load_mode;     // Pins act as register inputs
    logic [13:0] jk_next;       // J-K result for both registers

    assign clk_rise   = pin_s2.seq_clk & ~clk_prev_reg;
    assign clk_fall   = ~pin_s2.seq_clk & clk_prev_reg;
    // Virgin option bit is zero, so the shared pin starts as preset
    assign preset_act = ~oe_opt_reg & pin_s2.preset_or_enable;
    // Enable is active low; preset option always drives
    assign drive_ok   = ~oe_opt_reg | ~pin_s2.preset_or_enable;
    assign load_mode  = pin_s2.state_load | pin_s2.output_load;
    assign jk_next    = jk_update({out_reg, state_reg}, j_vec, k_vec);

    // Next state for registers, lockout and pins
    always_comb
    begin
        state_next   = state_reg;
        out_next     = out_reg;
        lockout_next = lockout_reg;
        if (preset_act)
        begin
            // Asynchronous to the sequencer clock; clocking blocked
            state_next   = `PMS_STATE_RESET;
            out_next     = `PMS_OUT_RESET;
            lockout_next = 1'b1;
        end
        else if (lockout_reg)
        begin
            // A full clock pulse must follow a falling edge first
            if (clk_fall)
            begin
                lockout_next = 1'b0;
            end
        end
        else if (clk_rise)
        begin
            // Outside preset, registers change only here
            if (pin_s2.state_load)
            begin
                state_next = pin_s2.pins_in[5:0];
            end
            else if (!pin_s2.output_load)
            begin
                state_next = jk_next[5:0];
            end
            if (pin_s2.output_load)
            begin
                out_next = pin_s2.pins_in;
            end
            else if (!pin_s2.state_load && !pin_s2.state_observe)
            begin
                // Observe and state load leave outputs untouched
                out_next = jk_next[13:6];
            end
        end
        // Observe puts state on the six low pins
        if (pin_s2.state_observe)
        begin
            pins_next = {out_next[7:6], state_next};
        end
        else
        begin
            pins_next = out_next;
        end
        // Load modes release the pins for the outside party; state load
        // frees only the six low pins, so the top two keep driving
        pins_oe_next = {{2{drive_ok & ~pin_s2.output_load}},
                        {6{drive_ok & ~load_mode}}};
    end

    // Power-up leaves state, outputs and pins at ones, even without preset in use
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg    <= `PMS_STATE_RESET;
            out_reg      <= `PMS_OUT_RESET;
            oe_opt_reg   <= `PMS_CFG_RESET;
            clk_prev_reg <= 1'b0;
            lockout_reg  <= 1'b0;
            pins_reg     <= `PMS_OUT_RESET;
            pins_oe_reg  <= 8'hff;
        end
        else
        begin
            state_reg    <= state_next;
            out_reg      <= out_next;
            oe_opt_reg   <= oe_opt_next;
            clk_prev_reg <= pin_s2.seq_clk;
            lockout_reg  <= lockout_next;
            pins_reg     <= pins_next;
            pins_oe_reg  <= pins_oe_next;
        end
    end

    assign output_pins_o    = pins_reg;
    assign output_pins_oe_o = pins_oe_reg;

endmodule : pms_sequencer

// ---- verif/pms_ext_model.sv ----
// Model of the surrounding logic: sequencer clock pulses and forced pin levels
`timescale 1ns/1ns

module pms_ext_model (
    input  wire logic       clk_i,     // System clock
    input  wire logic       go_i,      // Pulse request
    input  wire logic       drv_i,     // Force floated pins
    input  wire logic [7:0] hold_i,    // Levels to force
    input  wire logic [7:0] pins_o_i,  // Device pin drive
    input  wire logic [7:0] pins_oe_i, // Device pin enable
    output logic            seq_clk_o, // Sequencer clock, low between pulses
    output logic            busy_o,    // Pulse in progress
    output logic [7:0]      pins_i_o   // Resolved pin levels
);
    // --------------------
    // Pulse timing
    // --------------------
    logic [3:0] phase_reg = 4'h0; // Position in a twelve cycle pulse

    // Six cycles high, six low: the sync stages must see both edges
    always @(posedge clk_i)
    begin
        if (go_i && phase_reg == 4'h0)
            phase_reg <= 4'h1;
        else if (phase_reg == 4'hc)
            phase_reg <= 4'h0;
        else if (phase_reg != 4'h0)
            phase_reg <= phase_reg + 4'h1;
    end

    // Clock stands still outside pulses
    assign seq_clk_o = (phase_reg != 4'h0) && (phase_reg < 4'h7);
    assign busy_o    = (phase_reg != 4'h0);

    // Floated pins: forced level in load modes, else the inverse of the last drive
    assign pins_i_o = (pins_oe_i & pins_o_i)
                    | (~pins_oe_i & (drv_i ? hold_i : ~pins_o_i));
endmodule : pms_ext_model

// ---- verif/pms_sequencer_properties.sv ----
// Concurrent checks on the sequencer ports
`timescale 1ns/1ns

module pms_seq_props (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [31:0] rdata_o,
    input  wire logic        seq_clk_i,
    input  wire logic        preset_or_enable_pin_i,
    input  wire logic        state_observe_input_i,
    input  wire logic        state_load_input_i,
    input  wire logic        output_load_input_i,
    input  wire logic [7:0]  output_pins_o,
    input  wire logic [7:0]  output_pins_oe_o
);
    // --------------------
    // Helpers
    // --------------------
    wire pre = preset_or_enable_pin_i; // Shared pin
    wire so  = state_observe_input_i;  // Observe mode
    wire ld  = state_load_input_i | output_load_input_i; // Any load mode
    logic oe_opt; // Tracked enable option, mirrors the config bit

    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
            oe_opt <= 1'h0;
        else if (wr_i && addr_i == 8'hc0)
            oe_opt <= wdata_i[0];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // --------------------
    // Assertions
    // --------------------
    a_reset_all_ones: assert property ($rose(rst_b_i) |->
        output_pins_o == 8'hff && output_pins_oe_o == 8'hff)
        else $error("reset pins");
    a_config_option: assert property (rd_i && addr_i == 8'hc0 |=>
        rdata_o == {31'h0, oe_opt}) else $error("config read");
    a_enable_floats: assert property ((oe_opt && pre)[*5] |->
        output_pins_oe_o == 8'h00) else $error("enable ignored");
    a_preset_forces_ones: assert property ((!oe_opt && pre && !ld)[*5] |->
        output_pins_o == 8'hff && output_pins_oe_o == 8'hff)
        else $error("preset missed");
    a_out_load_floats: assert property (output_load_input_i[*5] |->
        output_pins_oe_o == 8'h00) else $error("output load drive");
    a_state_load_floats: assert property (state_load_input_i[*5] |->
        output_pins_oe_o[5:0] == 6'h00) else $error("state load drive");
    a_pins_hold_still: assert property (
        (!seq_clk_i && !ld && $stable({pre, so, oe_opt}))[*6] |=> $stable(output_pins_o))
        else $error("pins moved unclocked");
    a_observe_shows_state: assert property (
        (so && !seq_clk_i && !ld)[*6] ##0 (rd_i && addr_i == 8'hc1) |=>
        {2'h0, rdata_o[5:0]} == ($past(output_pins_o) & 8'h3f))
        else $error("observe mismatch");
    a_pins_show_outputs: assert property (
        (!so && !seq_clk_i && !ld)[*6] ##0 (rd_i && addr_i == 8'hc1) |=>
        rdata_o[15:8] == $past(output_pins_o))
        else $error("output mismatch");
endmodule : pms_seq_props

bind pms_sequencer pms_seq_props pms_seq_props_inst (
    .clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .seq_clk_i,
    .preset_or_enable_pin_i, .state_observe_input_i, .state_load_input_i,
    .output_load_input_i, .output_pins_o, .output_pins_oe_o);

// ---- verif/pms_testbench.sv ----
// Self-checking testbench for the programmable Mealy sequencer
`timescale 1ns/1ns
`include "pms_consts.svh"

module testbench;
    // --------------------
    // Signals
    // --------------------
    logic        clk_i   = 1'h0;  // System clock, 40 ns
    logic        rst_b_i = 1'h0;  // Reset, active low
    logic [7:0]  addr_i  = 8'h00; // Register address
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i    = 1'h0;
    logic        rd_i    = 1'h0;
    logic        pre     = 1'h0;  // Shared preset or enable pin
    logic        so      = 1'h0;  // Observe mode
    logic        sl      = 1'h0;  // State load mode
    logic        ol      = 1'h0;  // Output load mode
    logic        go      = 1'h0;  // Pulse request
    logic [15:0] lin     = 16'h0; // AND array inputs
    logic [7:0]  hold    = 8'h00; // Forced pin level
    logic [31:0] rdata_o;
    logic        seq_clk;
    logic        busy;
    logic [7:0]  pin_in;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    int          miscompares = 0;
    int          checked     = 0;
    int          cycles      = 0;

    pms_sequencer pms_sequencer_inst (
        .clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .seq_clk_i(seq_clk),
        .preset_or_enable_pin_i(pre), .state_observe_input_i(so),
        .state_load_input_i(sl), .output_load_input_i(ol), .logic_in_i(lin),
        .output_pins_i(pin_in), .output_pins_o(pin_out), .output_pins_oe_o(pin_oe));

    pms_ext_model pms_ext_model_inst (
        .clk_i(clk_i), .go_i(go), .drv_i(sl | ol), .hold_i(hold), .pins_o_i(pin_out),
        .pins_oe_i(pin_oe), .seq_clk_o(seq_clk), .busy_o(busy), .pins_i_o(pin_in));

    // --------------------
    // Clock and hang guard
    // --------------------
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    // Whole run needs well under 2000 cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    // --------------------
    // Shared tasks
    // --------------------
    task automatic print_verdict;
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] exp, got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'h1;
        @(posedge clk_i);
        wr_i    <= 1'h0;
    endtask : wr

    // Read data stands from the cycle after the strobe until the next read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'h1;
        @(posedge clk_i);
        rd_i   <= 1'h0;
        @(posedge clk_i);
        d = rdata_o;
    endtask : rd

    task automatic st(input logic [5:0] s, input logic [7:0] q);
        logic [31:0] d;
        rd(`PMS_ADDR_STATUS, d);
        chk("status", {16'h0, q, 2'h0, s}, d & 32'hffff);
    endtask : st

    task automatic prog(input int t, input logic [31:0] tr, cp, j, k);
        wr(8'(t * 4), tr);
        wr(8'(t * 4 + 1), cp);
        wr(8'(t * 4 + 2), j);
        wr(8'(t * 4 + 3), k);
    endtask : prog

    // Pins pass two sync stages, so allow a few cycles
    task automatic settle;
        repeat (6) @(posedge clk_i);
    endtask : settle

    task automatic pulse;
        @(posedge clk_i);
        go <= 1'h1;
        @(posedge clk_i);
        go <= 1'h0;
        @(posedge clk_i);
        for (int i = 0; i < 40 && busy; i++) @(posedge clk_i);
        settle();
    endtask : pulse

    task automatic do_reset;
        rst_b_i <= 1'h0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'h1;
        @(posedge clk_i);
    endtask : do_reset

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_virgin;
        logic [31:0] d;
        chk("pins", 32'hff, 32'(pin_out));
        chk("pins_oe", 32'hff, 32'(pin_oe));
        st(6'h3f, 8'hff);
        rd(`PMS_ADDR_CONFIG, d);
        chk("config", 32'h0, d);
        rd(8'hfe, d);
        chk("unmapped", 32'h0, d);
        pulse();
        st(6'h3f, 8'hff);
    endtask : t_virgin

    task automatic t_jk;
        do_reset();
        prog(0, 32'h0, 32'h0, 32'h0, 32'h3c01);
        pulse();
        st(6'h3e, 8'h0f);
        so <= 1'h1;
        settle();
        chk("observe", 32'h3e, 32'(pin_out));
        st(6'h3e, 8'h0f);
        so <= 1'h0;
        settle();
        chk("logic", 32'h0f, 32'(pin_out));
        prog(0, 32'h0, 32'h0, 32'h3c01, 32'h3c01);
        pulse();
        st(6'h3f, 8'hff);
    endtask : t_jk

    // Term 0 feeds the complement; term 1 toggles bit 1 on it
    task automatic t_comp;
        do_reset();
        prog(0, 32'h1, 32'h0, 32'h0, 32'h4000);
        prog(1, 32'h400000, 32'h0, 32'h80, 32'h80);
        lin <= 16'h1;
        pulse();
        st(6'h3f, 8'hff);
        lin <= 16'h0;
        pulse();
        st(6'h3f, 8'hfd);
    endtask : t_comp

    task automatic t_load;
        do_reset();
        sl   <= 1'h1;
        hold <= 8'h2a;
        settle();
        chk("oe_sload", 32'hc0, 32'(pin_oe));
        pulse();
        st(6'h2a, 8'hff);
        sl   <= 1'h0;
        ol   <= 1'h1;
        hold <= 8'h5a;
        settle();
        chk("oe_oload", 32'h0, 32'(pin_oe));
        pulse();
        st(6'h2a, 8'h5a);
        ol <= 1'h0;
        settle();
        chk("pins", 32'h5a, 32'(pin_out));
    endtask : t_load

    task automatic t_preset;
        do_reset();
        prog(0, 32'h0, 32'h0, 32'h0, 32'h3c00);
        pulse();
        pre <= 1'h1;
        settle();
        chk("pins_preset", 32'hff, 32'(pin_out));
        pulse();
        st(6'h3f, 8'hff);
        pre <= 1'h0;
        pulse();
        st(6'h3f, 8'hff);
        pulse();
        st(6'h3f, 8'h0f);
    endtask : t_preset

    task automatic t_oe;
        logic [31:0] d;
        do_reset();
        wr(`PMS_ADDR_CONFIG, 32'h1);
        rd(`PMS_ADDR_CONFIG, d);
        chk("config", 32'h1, d);
        wr(`PMS_ADDR_STATUS, 32'h0);
        pre <= 1'h1;
        settle();
        chk("oe_off", 32'h0, 32'(pin_oe));
        st(6'h3f, 8'hff);
        pre <= 1'h0;
        settle();
        chk("oe_on", 32'hff, 32'(pin_oe));
    endtask : t_oe

    initial
    begin
        do_reset();
        t_virgin();
        t_jk();
        t_comp();
        t_load();
        t_preset();
        t_oe();
        print_verdict();
    end
endmodule : testbench
